// [design/serial_pll_divider_control.sv]
// Serial-loaded reference and pulse-swallow divider core with APB status
// Functional notes
// - Each serial clock rising edge shifts data into both shift registers.
// - The last bit shifted in selects which latch gets the word.
// - Control bit high with strobe high loads the 15-bit reference latch.
// - Control bit low with strobe high loads the 18-bit main latch.
// - Strobe has a pull-up; high or open strobe performs the transfer. The core models no pull-up; only a driven-high strobe transfers.
// - Speed-up output is floating except strobe high while pump drives.
// - Low phase-sense select inverts charge-pump and comparator outputs.
// - Monitor shows reference pulse when sense high, feedback when low.
// - Lock output high, low while any phase difference exists.
// - Seven-bit swallow counter takes presets zero to 127.
// - Eleven-bit programmable counter takes ratios sixteen to 2047.
// - Fourteen-bit reference counter takes ratios eight to 16383.
// - One latched bit chooses between the two prescaler moduli.
// - Two comparator outputs; feedback-side one is open-drain N-channel.
// - Modulus select high means 32/33, low means 64/65.
// - Main word bits one to seven swallow, eight to eighteen ratio.
// - Output frequency is (P*N+A)*fref/R, with A below N.
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/10ps
module serial_pll_divider_control (
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  input wire logic SERIAL_DATA_I,
  input wire logic SERIAL_CLK_I,
  input wire logic LOAD_LATCH_STROBE_I,
  input wire logic PHASE_SENSE_SELECT_I,
  input wire logic REF_OSC_I,
  input wire logic PRESCALER_OUT_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic MODULUS_HIGH_O,
  output logic PRESCALER_MODULUS_SELECT_O,
  output logic CHARGE_PUMP_O,
  output logic CHARGE_PUMP_OE_O,
  output logic PHASE_REF_O,
  output logic PHASE_FB_O,
  output logic PHASE_FB_OE_O,
  output logic SPEEDUP_SWITCH_OUTPUT_O,
  output logic SPEEDUP_SWITCH_OUTPUT_OE_O,
  output logic LOCK_DETECT_OUTPUT_O,
  output logic COMPARATOR_MONITOR_OUTPUT_O
);
  localparam int unsigned PIN_N = pll_div_pkg::SYNC_W;

  // Two-stage synchronisers for the six serial, sense and clock pin inputs (not the APB inputs), plus an edge history stage
  logic [PIN_N-1:0] pins;
  logic [PIN_N-1:0] sync_a;
  logic [PIN_N-1:0] sync_b;
  logic [PIN_N-1:0] sync_c;
  logic [PIN_N-1:0] rise;

  assign pins = {PRESCALER_OUT_I, REF_OSC_I, PHASE_SENSE_SELECT_I,
                 LOAD_LATCH_STROBE_I, SERIAL_CLK_I, SERIAL_DATA_I};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_sync
      always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
          sync_c[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= pins[gi];
          sync_b[gi] <= sync_a[gi];
          sync_c[gi] <= sync_b[gi];
        end
      end
      assign rise[gi] = sync_b[gi] & ~sync_c[gi];
    end
  endgenerate

  logic serial_bit;
  logic shift_edge;
  logic strobe;
  logic sense;
  assign serial_bit = sync_b[pll_div_pkg::SY_DATA];
  assign shift_edge = rise[pll_div_pkg::SY_SCLK];
  assign strobe = sync_b[pll_div_pkg::SY_LOAD];
  assign sense = sync_b[pll_div_pkg::SY_SENSE];

  // Serial shift registers and latches
  logic [pll_div_pkg::MAIN_SHIFT_W-1:0] main_shift;
  logic [pll_div_pkg::MAIN_SHIFT_W-1:0] next_main_shift;
  logic [pll_div_pkg::REF_SHIFT_W-1:0] ref_shift;
  logic [pll_div_pkg::REF_SHIFT_W-1:0] next_ref_shift;
  pll_div_pkg::ref_latch_s ref_latch;
  pll_div_pkg::ref_latch_s next_ref_latch;
  pll_div_pkg::main_latch_s main_latch;
  pll_div_pkg::main_latch_s next_main_latch;

  always_comb begin
    next_main_shift = main_shift;
    next_ref_shift = ref_shift;
    next_ref_latch = ref_latch;
    next_main_latch = main_latch;
    if (shift_edge) begin
      // MSB arrives first, so shifting left leaves the control bit in bit 0
      next_main_shift = {main_shift[pll_div_pkg::MAIN_SHIFT_W-2:0],
                         serial_bit};
      next_ref_shift = {ref_shift[pll_div_pkg::REF_SHIFT_W-2:0],
                        serial_bit};
    end
    // Latches follow the shift registers while the strobe stays high
    if (strobe) begin
      if (ref_shift[0]) begin
        next_ref_latch = pll_div_pkg::ref_latch_s'(
          ref_shift[pll_div_pkg::REF_SHIFT_W-1:1]);
      end
      if (!main_shift[0]) begin
        next_main_latch = pll_div_pkg::main_latch_s'(
          main_shift[pll_div_pkg::MAIN_SHIFT_W-1:1]);
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      main_shift <= '0;
      ref_shift <= '0;
      ref_latch <= pll_div_pkg::REF_LATCH_RESET;
      main_latch <= pll_div_pkg::MAIN_LATCH_RESET;
    end else begin
      main_shift <= next_main_shift;
      ref_shift <= next_ref_shift;
      ref_latch <= next_ref_latch;
      main_latch <= next_main_latch;
    end
  end

  // Control register written over APB
  logic run;

  // Reference divider
  logic ref_pulse;
  reload_counter #(
    .WIDTH(pll_div_pkg::REFCNT_W)
  ) u_ref_counter (
    .clk_i(SYS_CLK_I),
    .reset_n_i(RESET_N_I),
    .tick_i(rise[pll_div_pkg::SY_REF] & run),
    .load_i(ref_latch.ref_ratio),
    .terminal_o(ref_pulse),
    .count_o()
  );

  // Programmable counter; every prescaler output rising edge while run is set is one count
  logic fb_pulse;
  reload_counter #(
    .WIDTH(pll_div_pkg::PROG_W)
  ) u_prog_counter (
    .clk_i(SYS_CLK_I),
    .reset_n_i(RESET_N_I),
    .tick_i(rise[pll_div_pkg::SY_PRE] & run),
    .load_i(main_latch.prog_ratio),
    .terminal_o(fb_pulse),
    .count_o()
  );

  // Swallow counter: high modulus while nonzero, reloaded per feedback cycle
  logic [pll_div_pkg::SWALLOW_W-1:0] swallow;
  logic [pll_div_pkg::SWALLOW_W-1:0] next_swallow;
  logic mod_high;
  logic next_mod_high;
  logic mod_sel;
  logic next_mod_sel;

  always_comb begin
    next_swallow = swallow;
    if (fb_pulse) begin
      next_swallow = main_latch.swallow_count;
    end else if (rise[pll_div_pkg::SY_PRE] && run &&
                 swallow != '0) begin
      next_swallow = swallow - pll_div_pkg::SWALLOW_W'(1);
    end
    // With A below N the swallow expires first, giving (P+1)*A + P*(N-A)
    next_mod_high = (next_swallow != '0);
    next_mod_sel = ref_latch.prescaler_modulus_select;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      swallow <= '0;
      mod_high <= 1'b0;
      mod_sel <= 1'b0;
    end else begin
      swallow <= next_swallow;
      mod_high <= next_mod_high;
      mod_sel <= next_mod_sel;
    end
  end

  // Phase-frequency detector on the divided pulses
  logic up;
  logic next_up;
  logic down;
  logic next_down;

  always_comb begin
    next_up = up;
    next_down = down;
    if (ref_pulse && fb_pulse) begin
      next_up = 1'b0;
      next_down = 1'b0;
    end else if (ref_pulse) begin
      next_up = !down;
      next_down = 1'b0;
    end else if (fb_pulse) begin
      next_down = !up;
      next_up = 1'b0;
    end
  end

  // Output stage: every pin except the tied-low PHASE_FB_O comes from a flip-flop
  logic pump;
  logic next_pump;
  logic pump_oe;
  logic next_pump_oe;
  logic phase_ref;
  logic next_phase_ref;
  logic phase_fb_oe;
  logic next_phase_fb_oe;
  logic speedup;
  logic next_speedup;
  logic speedup_oe;
  logic next_speedup_oe;
  logic lock;
  logic next_lock;
  logic monitor;
  logic next_monitor;

  always_comb begin
    // Reference ahead drives high with sense high; low sense swaps roles
    next_pump_oe = next_up | next_down;
    next_pump = sense ? next_up : next_down;
    next_phase_ref = sense ? next_down : next_up;
    // Open-drain: only ever pulls low, enable marks the pull
    next_phase_fb_oe = sense ? next_up : next_down;
    next_speedup_oe = strobe & next_pump_oe;
    next_speedup = next_pump;
    next_lock = !(next_up | next_down);
    next_monitor = sense ? ref_pulse : fb_pulse;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      up <= 1'b0;
      down <= 1'b0;
      pump <= 1'b0;
      pump_oe <= 1'b0;
      phase_ref <= 1'b0;
      phase_fb_oe <= 1'b0;
      speedup <= 1'b0;
      speedup_oe <= 1'b0;
      lock <= 1'b1;
      monitor <= 1'b0;
    end else begin
      up <= next_up;
      down <= next_down;
      pump <= next_pump;
      pump_oe <= next_pump_oe;
      phase_ref <= next_phase_ref;
      phase_fb_oe <= next_phase_fb_oe;
      speedup <= next_speedup;
      speedup_oe <= next_speedup_oe;
      lock <= next_lock;
      monitor <= next_monitor;
    end
  end

  // APB slave: ready one cycle into the access phase
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic ready;
  logic next_ready;
  logic slverr;
  logic next_slverr;
  logic next_run;
  logic [31:0] status;

  always_comb begin
    status = '0;
    status[pll_div_pkg::ST_LOCK] = lock;
    status[pll_div_pkg::ST_UP] = up;
    status[pll_div_pkg::ST_DOWN] = down;
    status[pll_div_pkg::ST_SENSE] = sense;
    status[pll_div_pkg::ST_MODHI] = mod_high;
    status[pll_div_pkg::ST_STROBE] = strobe;
    status[pll_div_pkg::ST_MODSEL] = mod_sel;
  end

  always_comb begin
    next_ready = 1'b0;
    next_slverr = 1'b0;
    next_rdata = '0;
    next_run = run;
    if (PSEL_I && PENABLE_I && !ready) begin
      next_ready = 1'b1;
      case (PADDR_I)
        pll_div_pkg::CTRL_OFS: next_rdata[pll_div_pkg::CTRL_RUN_BIT] = run;
        pll_div_pkg::STATUS_OFS: next_rdata = status;
        pll_div_pkg::REF_WORD_OFS: next_rdata = 32'(ref_latch);
        pll_div_pkg::MAIN_WORD_OFS: next_rdata = 32'(main_latch);
        default: next_slverr = 1'b1;
      endcase
      if (PWRITE_I) begin
        next_rdata = '0;
      end
    end
    // A write lands at the edge where the master sees ready high
    if (PSEL_I && PENABLE_I && PWRITE_I && ready &&
        PADDR_I == pll_div_pkg::CTRL_OFS) begin
      next_run = PWDATA_I[pll_div_pkg::CTRL_RUN_BIT];
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      rdata <= '0;
      ready <= 1'b0;
      slverr <= 1'b0;
      run <= pll_div_pkg::CTRL_RUN_RESET;
    end else begin
      rdata <= next_rdata;
      ready <= next_ready;
      slverr <= next_slverr;
      run <= next_run;
    end
  end

  assign PRDATA_O = rdata;
  assign PREADY_O = ready;
  assign PSLVERR_O = slverr;
  assign MODULUS_HIGH_O = mod_high;
  assign PRESCALER_MODULUS_SELECT_O = mod_sel;
  assign CHARGE_PUMP_O = pump;
  assign CHARGE_PUMP_OE_O = pump_oe;
  assign PHASE_REF_O = phase_ref;
  assign PHASE_FB_O = 1'b0;
  assign PHASE_FB_OE_O = phase_fb_oe;
  assign SPEEDUP_SWITCH_OUTPUT_O = speedup;
  assign SPEEDUP_SWITCH_OUTPUT_OE_O = speedup_oe;
  assign LOCK_DETECT_OUTPUT_O = lock;
  assign COMPARATOR_MONITOR_OUTPUT_O = monitor;
endmodule

// [design/pll_div_pkg.sv]
// Constants and carrier types for the serial divider control core
package pll_div_pkg;
  localparam int unsigned MAIN_SHIFT_W = 19;
  localparam int unsigned REF_SHIFT_W = 16;
  localparam int unsigned MAIN_LATCH_W = 18;
  localparam int unsigned REF_LATCH_W = 15;
  localparam int unsigned SWALLOW_W = 7;
  localparam int unsigned PROG_W = 11;
  localparam int unsigned REFCNT_W = 14;
  localparam int unsigned SYNC_W = 6;
  // Synchroniser bit positions
  localparam int unsigned SY_DATA = 0;
  localparam int unsigned SY_SCLK = 1;
  localparam int unsigned SY_LOAD = 2;
  localparam int unsigned SY_SENSE = 3;
  localparam int unsigned SY_REF = 4;
  localparam int unsigned SY_PRE = 5;
  // APB register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] REF_WORD_OFS = 8'h08;
  localparam logic [7:0] MAIN_WORD_OFS = 8'h0c;
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam logic CTRL_RUN_RESET = 1'b1;
  // Status bit positions
  localparam int unsigned ST_LOCK = 0;
  localparam int unsigned ST_UP = 1;
  localparam int unsigned ST_DOWN = 2;
  localparam int unsigned ST_SENSE = 3;
  localparam int unsigned ST_MODHI = 4;
  localparam int unsigned ST_STROBE = 5;
  localparam int unsigned ST_MODSEL = 6;

  // Reference latch: modulus select on top, 14-bit ratio below
  typedef struct packed {
    logic prescaler_modulus_select;
    logic [REFCNT_W-1:0] ref_ratio;
  } ref_latch_s;

  // Main latch: programmable ratio on top, swallow count below
  typedef struct packed {
    logic [PROG_W-1:0] prog_ratio;
    logic [SWALLOW_W-1:0] swallow_count;
  } main_latch_s;

  localparam ref_latch_s REF_LATCH_RESET = '0;
  localparam main_latch_s MAIN_LATCH_RESET = '0;
endpackage

// [design/reload_counter.sv]
// Down counter that pulses and reloads at its terminal count
`timescale 1ns/10ps
module reload_counter #(
  parameter int unsigned WIDTH = 14
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic tick_i,
  input wire logic [WIDTH-1:0] load_i,
  output logic terminal_o,
  output logic [WIDTH-1:0] count_o
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic terminal;
  logic next_terminal;

  always_comb begin
    next_count = count;
    next_terminal = 1'b0;
    if (tick_i) begin
      // Reload at one so a ratio of R gives one pulse per R ticks
      if (count <= WIDTH'(1)) begin
        next_count = load_i;
        next_terminal = 1'b1;
      end else begin
        next_count = count - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      count <= '0;
      terminal <= 1'b0;
    end else begin
      count <= next_count;
      terminal <= next_terminal;
    end
  end

  assign terminal_o = terminal;
  assign count_o = count;
endmodule

// [bench/pll_div_properties.sv]
// Port checker for the serial divider control core
`timescale 1ns/10ps
module pll_div_properties (
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  input wire logic LOAD_LATCH_STROBE_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic MODULUS_HIGH_O,
  input wire logic CHARGE_PUMP_OE_O,
  input wire logic PHASE_FB_O,
  input wire logic PHASE_FB_OE_O,
  input wire logic SPEEDUP_SWITCH_OUTPUT_OE_O,
  input wire logic LOCK_DETECT_OUTPUT_O,
  input wire logic COMPARATOR_MONITOR_OUTPUT_O
);
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RESET_N_I);
  ready_after_access_a: assert property (
    PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
    else $error("ready missing after access");
  ready_one_cycle_a: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready longer than one cycle");
  error_with_ready_a: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error without ready");
  rdata_idle_zero_a: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
    else $error("read data outside answer");
  speedup_off_a: assert property (
    !LOAD_LATCH_STROBE_I [*5] |-> !SPEEDUP_SWITCH_OUTPUT_OE_O)
    else $error("speed-up output driven with strobe low");
  fb_open_drain_a: assert property (
    !PHASE_FB_O && (!PHASE_FB_OE_O || CHARGE_PUMP_OE_O))
    else $error("feedback output driven high or pulled without error");
  lock_low_a: assert property (
    CHARGE_PUMP_OE_O [*2] |-> !LOCK_DETECT_OUTPUT_O)
    else $error("lock high during phase difference");
  lock_high_a: assert property (
    !CHARGE_PUMP_OE_O [*2] |-> LOCK_DETECT_OUTPUT_O)
    else $error("lock low without phase difference");
  monitor_pulse_a: assert property (
    COMPARATOR_MONITOR_OUTPUT_O |=> !COMPARATOR_MONITOR_OUTPUT_O)
    else $error("monitor pulse too long");
  reset_state_a: assert property (disable iff (1'b0)
    !RESET_N_I |=> !CHARGE_PUMP_OE_O && !PHASE_FB_OE_O && !PREADY_O &&
    LOCK_DETECT_OUTPUT_O)
    else $error("outputs not at reset state");
  cover property (PSLVERR_O);
  cover property (SPEEDUP_SWITCH_OUTPUT_OE_O);
  cover property ($rose(MODULUS_HIGH_O));
endmodule

bind serial_pll_divider_control pll_div_properties pll_div_properties_i (.*);

// [bench/serial_host_model.sv]
// Host controller model that shifts divider words into the core
`timescale 1ns/10ps
module serial_host_model (
  input wire logic clk_i,
  output logic data_o,
  output logic sclk_o,
  output logic strobe_o
);
  initial begin
    data_o = 1'b0;
    sclk_o = 1'b0;
    strobe_o = 1'b0;
  end
  // Ref words use the low 16 bits; shift clock idles low between frames
  task automatic send(input logic [18:0] w, input bit to_ref);
    int n;
    n = to_ref ? 16 : 19;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk_i);
      data_o <= w[i];
      repeat (3) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      sclk_o <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    @(posedge clk_i);
    data_o <= ~w[0];
    strobe_o <= 1'b1;
    repeat (5) @(posedge clk_i);
    strobe_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic set_strobe(input logic v);
    @(posedge clk_i);
    strobe_o <= v;
  endtask
endmodule

// [bench/serial_pll_divider_control_test.sv]
// Self-checking bench for the serial divider control core
`timescale 1ns/10ps
module serial_pll_divider_control_test;
  logic clk, rst_n, sense, ref_osc, pre_out, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, modhi, modsel, pump, pump_oe, pref, pfb, pfb_oe;
  logic spd, spd_oe, lock, mon, sdata, sclk, strobe, err;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  int p, h;
  serial_host_model serial_host_model_i (.clk_i(clk), .data_o(sdata),
    .sclk_o(sclk), .strobe_o(strobe));
  serial_pll_divider_control serial_pll_divider_control_i (
    .SYS_CLK_I(clk), .RESET_N_I(rst_n), .SERIAL_DATA_I(sdata),
    .SERIAL_CLK_I(sclk), .LOAD_LATCH_STROBE_I(strobe),
    .PHASE_SENSE_SELECT_I(sense), .REF_OSC_I(ref_osc),
    .PRESCALER_OUT_I(pre_out), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .MODULUS_HIGH_O(modhi), .PRESCALER_MODULUS_SELECT_O(modsel),
    .CHARGE_PUMP_O(pump), .CHARGE_PUMP_OE_O(pump_oe), .PHASE_REF_O(pref),
    .PHASE_FB_O(pfb), .PHASE_FB_OE_O(pfb_oe),
    .SPEEDUP_SWITCH_OUTPUT_O(spd), .SPEEDUP_SWITCH_OUTPUT_OE_O(spd_oe),
    .LOCK_DETECT_OUTPUT_O(lock), .COMPARATOR_MONITOR_OUTPUT_O(mon));
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      failures++;
      results();
    end
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bchk(input logic got, input logic exp);
    check({31'h0, got}, {31'h0, exp});
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
    bchk(err, 1'b0);
  endtask
  // Toggle one clock input with a four-cycle period, count monitor pulses
  task automatic run(input int periods, input bit sel_ref);
    p = 0;
    h = 0;
    repeat (periods) begin
      for (int k = 0; k < 4; k++) begin
        @(posedge clk);
        if (sel_ref)
          ref_osc <= (k < 2);
        else
          pre_out <= (k < 2);
        p += (mon === 1'b1);
      end
      h += (modhi === 1'b1);
    end
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    sense = 1'b1;
    ref_osc = 1'b0;
    pre_out = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rchk(pll_div_pkg::CTRL_OFS, {31'h0, pll_div_pkg::CTRL_RUN_RESET});
    rchk(pll_div_pkg::REF_WORD_OFS, 32'h0);
    rchk(pll_div_pkg::MAIN_WORD_OFS, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    bchk(err, 1'b1);
    apb(1'b1, pll_div_pkg::REF_WORD_OFS, 32'hffff);
    rchk(pll_div_pkg::REF_WORD_OFS, 32'h0);
    apb(1'b1, pll_div_pkg::CTRL_OFS, 32'h0);
    rchk(pll_div_pkg::CTRL_OFS, 32'h0);
    apb(1'b1, pll_div_pkg::CTRL_OFS, 32'h1);
    rchk(pll_div_pkg::CTRL_OFS, 32'h1);
    apb(1'b0, pll_div_pkg::STATUS_OFS, 32'h0);
    bchk(rd[pll_div_pkg::ST_LOCK], 1'b1);
    $display("test registers done");
    for (int s = 0; s < 2; s++) begin
      serial_host_model_i.send({4'(s), 14'h8, 1'b1}, 1'b1);
      rchk(pll_div_pkg::REF_WORD_OFS, {17'h0, s[0], 14'h8});
      bchk(modsel, s[0]);
    end
    rchk(pll_div_pkg::MAIN_WORD_OFS, 32'h0);
    serial_host_model_i.send({11'h10, 7'h3, 1'b0}, 1'b0);
    rchk(pll_div_pkg::MAIN_WORD_OFS, 32'h803);
    rchk(pll_div_pkg::REF_WORD_OFS, 32'h4008);
    $display("test serial load done");
    sense <= 1'b0;
    run(32, 1'b0);
    run(48, 1'b0);
    check(p, 32'h3);
    check(h, 32'h9);
    $display("test main divider done");
    sense <= 1'b1;
    run(16, 1'b1);
    run(24, 1'b1);
    check(p, 32'h3);
    bchk(pump_oe, 1'b1);
    bchk(pump, 1'b1);
    bchk(pfb_oe, 1'b1);
    bchk(pref, 1'b0);
    bchk(lock, 1'b0);
    sense <= 1'b0;
    repeat (6) @(posedge clk);
    bchk(pump, 1'b0);
    bchk(pref, 1'b1);
    bchk(pfb_oe, 1'b0);
    serial_host_model_i.set_strobe(1'b1);
    repeat (6) @(posedge clk);
    bchk(spd_oe, 1'b1);
    bchk(spd, 1'b0);
    serial_host_model_i.set_strobe(1'b0);
    repeat (6) @(posedge clk);
    bchk(spd_oe, 1'b0);
    $display("test comparator done");
    results();
  end
endmodule
